/* File: iepb_top.sv */
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
// What this block does
// [R1] global gate bit 7 of primary enable blocks all sources when clear
// [R2] primary bit 6 masks the serial peripheral unit requests
// [R3] primary bit 5 gates both timer two overflow flags
// [R4] primary bit 4 gates the async serial unit request
// [R5] primary bit 3 gates the timer one overflow flag
// [R6] primary bit 2 gates external line one
// [R7] primary bit 1 gates the timer zero overflow flag
// [R8] primary bit 0 gates external line zero
// [R9] primary enable at index a8, resets zero, fully read/write
// [R10] primary priority at index b8, resets 80, top bit read-only
// [R11] priority bit 1 means high; bits 6..0 map to the first seven sources
// [R12] extended enable at index e6, resets zero, all bits read/write
// [R13] extended bit 7 gates both timer three overflow flags
// [R14] extended bit 6 gates comparator one rise and fall flags
// [R15] extended bit 5 gates comparator zero rise and fall flags
// [R16] extended bit 4 masks all counter array requests
// [R17] extended bit 3 gates the conversion done flag
// [R18] extended bit 2 gates the conversion window flag
// [R19] extended bit 1 gates real-time clock alarm and oscillator lost flags
// [R20] extended bit 0 masks the two-wire bus unit requests
// [R21] high request preempts low service; high service is never preempted
// [R22] higher level first, then lowest source order number
// [R23] pending requests are sampled and decoded every clock cycle
// [R24] request shown only when pending, masked in, and gate set
module iepb_top
   import iepb_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_line_zero_n,
   input wire logic ext_line_one_n,
   input wire logic timer_zero_overflow,
   input wire logic timer_one_overflow,
   input wire logic async_serial_unit_flag,
   input wire logic timer_two_low_overflow,
   input wire logic timer_two_high_overflow,
   input wire logic serial_periph_flag,
   input wire logic two_wire_bus_unit_flag,
   input wire logic rt_clock_alarm_flag,
   input wire logic rt_clock_osc_lost_flag,
   input wire logic conv_window_flag,
   input wire logic conv_done_flag,
   input wire logic counter_array_unit_flag,
   input wire logic comparator_zero_rise_flag,
   input wire logic comparator_zero_fall_flag,
   input wire logic comparator_one_rise_flag,
   input wire logic comparator_one_fall_flag,
   input wire logic timer_three_low_overflow,
   input wire logic timer_three_high_overflow,
   input wire logic irq_ack,
   input wire logic irq_return,
   output logic irq_valid,
   output logic [SRCW-1:0] irq_source,
   output logic irq_high
);

   ////////////////////////////////////////////////////////////////
   // helpers

   // lowest set bit wins, so order number 0 beats the rest
   function automatic logic [SRCW-1:0] iepb_first(input logic [NSRC-1:0] v);
      logic [SRCW-1:0] idx;
      idx = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = SRCW'(i);
         end
      end
      return idx;
   endfunction : iepb_first

   // true when the address hits a mapped word
   function automatic logic iepb_hit(input logic [11:0] a);
      return (a == ADDR_ENA_PRI) || (a == ADDR_PRIO_PRI) ||
         (a == ADDR_ENA_EXT) || (a == ADDR_STATUS);
   endfunction : iepb_hit

   ////////////////////////////////////////////////////////////////
   // registers

   logic [7:0] interrupt_enable_primary;
   logic [7:0] interrupt_priority_primary;
   logic [7:0] interrupt_enable_extended;
   logic wr_en;
   logic high_busy;
   logic low_busy;

   assign wr_en = psel && penable && pwrite;

   // primary enable, all bits read/write
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         interrupt_enable_primary <= ENA_PRI_RST; // R9
      end else if (wr_en && paddr == ADDR_ENA_PRI) begin
         interrupt_enable_primary <= pwdata[7:0]; // R9
      end
   end

   // priority; top bit is unused and always reads one
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         interrupt_priority_primary <= PRIO_PRI_RST; // R10
      end else if (wr_en && paddr == ADDR_PRIO_PRI) begin
         interrupt_priority_primary <= {PRIO_PRI_RST[PRIO_RO_BIT], pwdata[6:0]}; // R10
      end
   end

   // extended enable, all bits read/write
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         interrupt_enable_extended <= ENA_EXT_RST; // R12
      end else if (wr_en && paddr == ADDR_ENA_EXT) begin
         interrupt_enable_extended <= pwdata[7:0]; // R12
      end
   end

   // zero wait states; unmapped words answer with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !iepb_hit(paddr);

   // read mux; status is read-only, writes to it are dropped
   always_comb begin
      prdata = '0;
      case (paddr)
         ADDR_ENA_PRI: prdata[7:0] = interrupt_enable_primary;
         ADDR_PRIO_PRI: prdata[7:0] = interrupt_priority_primary;
         ADDR_ENA_EXT: prdata[7:0] = interrupt_enable_extended;
         ADDR_STATUS: begin
            prdata[SRCW-1:0] = irq_source;
            prdata[ST_HIGH] = irq_high;
            prdata[ST_VALID] = irq_valid;
            prdata[ST_LOW_BUSY] = low_busy;
            prdata[ST_HIGH_BUSY] = high_busy;
         end
         default: prdata = '0;
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // external line synchronisers

   logic [1:0] ext_s1;
   logic [1:0] ext_s2;
   logic [1:0] ext_s3;
   logic [1:0] ext_level_n;

   // three stages; first stage only feeds the second
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ext_s1 <= 2'b11;
         ext_s2 <= 2'b11;
         ext_s3 <= 2'b11;
      end else begin
         ext_s1 <= {ext_line_one_n, ext_line_zero_n};
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
      end
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ext_level_n <= 2'b11;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (ext_s2[i] == ext_s3[i]) begin
               ext_level_n[i] <= ext_s3[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // pending, mask and level vectors

   logic [NSRC-1:0] pend;
   logic [NSRC-1:0] mask;
   logic [NSRC-1:0] level;
   logic gate;

   // pending flags in source order; lines are active low
   assign pend = {
      timer_three_high_overflow | timer_three_low_overflow,
      comparator_one_rise_flag | comparator_one_fall_flag,
      comparator_zero_rise_flag | comparator_zero_fall_flag,
      counter_array_unit_flag,
      conv_done_flag,
      conv_window_flag,
      rt_clock_alarm_flag | rt_clock_osc_lost_flag,
      two_wire_bus_unit_flag,
      serial_periph_flag,
      timer_two_high_overflow | timer_two_low_overflow,
      async_serial_unit_flag,
      timer_one_overflow,
      !ext_level_n[1],
      timer_zero_overflow,
      !ext_level_n[0]
   };

   // per-source masks
   assign gate = interrupt_enable_primary[GATE_BIT]; // R1
   assign mask[0] = interrupt_enable_primary[0]; // R8
   assign mask[1] = interrupt_enable_primary[1]; // R7
   assign mask[2] = interrupt_enable_primary[2]; // R6
   assign mask[3] = interrupt_enable_primary[3]; // R5
   assign mask[4] = interrupt_enable_primary[4]; // R4
   assign mask[5] = interrupt_enable_primary[5]; // R3
   assign mask[6] = interrupt_enable_primary[6]; // R2
   assign mask[7] = interrupt_enable_extended[0]; // R20
   assign mask[8] = interrupt_enable_extended[1]; // R19
   assign mask[9] = interrupt_enable_extended[2]; // R18
   assign mask[10] = interrupt_enable_extended[3]; // R17
   assign mask[11] = interrupt_enable_extended[4]; // R16
   assign mask[12] = interrupt_enable_extended[5]; // R15
   assign mask[13] = interrupt_enable_extended[6]; // R14
   assign mask[14] = interrupt_enable_extended[7]; // R13

   // extended sources have no priority bit here, so they stay low
   assign level = {{(NSRC - PRIMARY_SRCS){1'b0}},
      interrupt_priority_primary[PRIMARY_SRCS-1:0]}; // R11

   ////////////////////////////////////////////////////////////////
   // arbitration

   logic [NSRC-1:0] cand;
   logic [NSRC-1:0] hi_cand;
   logic [NSRC-1:0] allowed;
   logic next_valid;
   logic next_high;

   assign cand = pend & mask & {NSRC{gate}}; // R24 R1
   assign hi_cand = cand & level; // R11

   // in-service level limits who may be shown
   always_comb begin
      if (high_busy) begin
         allowed = '0; // R21
      end else if (low_busy || |hi_cand) begin
         allowed = hi_cand; // R21 R22
      end else begin
         allowed = cand; // R22
      end
   end

   assign next_valid = |allowed;
   assign next_high = |hi_cand;

   // decoded afresh on every edge
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_valid <= 1'b0;
         irq_source <= '0;
         irq_high <= 1'b0;
      end else begin
         irq_valid <= next_valid; // R23
         irq_source <= iepb_first(allowed); // R22
         irq_high <= next_valid && next_high; // R22
      end
   end

   ////////////////////////////////////////////////////////////////
   // in-service tracking from the core's ack and return pulses

   // high service entered on ack of a high request
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         high_busy <= 1'b0;
      end else if (irq_ack && irq_valid && irq_high) begin
         high_busy <= 1'b1; // R21
      end else if (irq_return) begin
         high_busy <= 1'b0;
      end
   end

   // a low routine resumes after the high one returns
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         low_busy <= 1'b0;
      end else if (irq_ack && irq_valid && !irq_high) begin
         low_busy <= 1'b1;
      end else if (irq_return && !high_busy) begin
         low_busy <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   logic [NSRC-1:0] below_mask;
   assign below_mask = NSRC'((16'h0001 << irq_source) - 16'h0001);

   property p_gate_off;
      !gate |=> !irq_valid;
   endproperty
   a_gate_off: assert property (p_gate_off) else $error("gate off but request"); // R1

   property p_src_ok;
      irq_valid |-> ($past(cand) & (NSRC'(1) << irq_source)) != '0; // index names a source that was in cand one cycle earlier
   endproperty
   a_src_ok: assert property (p_src_ok) else $error("shown source not enabled"); // R24

   property p_spi_mask;
      irq_valid && irq_source == SRC_SPI |-> $past(interrupt_enable_primary[6]);
   endproperty
   a_spi_mask: assert property (p_spi_mask) else $error("spi masked but shown"); // R2

   property p_t2_mask;
      irq_valid && irq_source == SRC_T2 |-> $past(interrupt_enable_primary[5]);
   endproperty
   a_t2_mask: assert property (p_t2_mask) else $error("timer two masked but shown"); // R3

   property p_t3_mask;
      irq_valid && irq_source == SRC_T3 |-> $past(interrupt_enable_extended[7]);
   endproperty
   a_t3_mask: assert property (p_t3_mask) else $error("timer three masked but shown"); // R13

   property p_high_first;
      irq_valid && !irq_high |-> $past(hi_cand) == '0;
   endproperty
   a_high_first: assert property (p_high_first) else $error("low beat high"); // R22

   property p_order;
      irq_valid |-> ($past(allowed) & below_mask) == '0;
   endproperty
   a_order: assert property (p_order) else $error("lower order source skipped"); // R22

   property p_no_preempt;
      high_busy |=> !irq_valid;
   endproperty
   a_no_preempt: assert property (p_no_preempt) else $error("high service preempted"); // R21

   property p_low_preempt;
      low_busy && !high_busy && |hi_cand |=> irq_valid && irq_high;
   endproperty
   a_low_preempt: assert property (p_low_preempt) else $error("high did not preempt"); // R21

   property p_every_cycle;
      !high_busy && !low_busy && |cand |=> irq_valid;
   endproperty
   a_every_cycle: assert property (p_every_cycle) else $error("request not decoded"); // R23

   property p_prio_top;
      interrupt_priority_primary[PRIO_RO_BIT] ##1 interrupt_priority_primary[PRIO_RO_BIT];
   endproperty
   a_prio_top: assert property (p_prio_top) else $error("priority top bit lost"); // R10

   property p_rst_vals;
      $past(rst) |-> interrupt_enable_primary == ENA_PRI_RST &&
         interrupt_enable_extended == ENA_EXT_RST;
   endproperty
   a_rst_vals: assert property (disable iff (1'b0) p_rst_vals) else $error("bad reset"); // R9 R12

   c_low_req: cover property (irq_valid && !irq_high);
   c_high_req: cover property (irq_valid && irq_high);
   c_preempt: cover property (low_busy && irq_valid && irq_high);
   c_ext_req: cover property (irq_valid && irq_source == SRC_EXT0);
endmodule : iepb_top

/* File: iepb_pkg.sv */
package iepb_pkg;
   // source count and index width
   localparam int NSRC = 15;
   localparam int SRCW = 4;
   // printed offsets are register indices; byte address is index * 4
   localparam logic [9:0] IDX_ENA_PRI = 10'h0a8;
   localparam logic [9:0] IDX_PRIO_PRI = 10'h0b8;
   localparam logic [9:0] IDX_ENA_EXT = 10'h0e6;
   localparam logic [9:0] IDX_STATUS = 10'h0f0;
   localparam logic [11:0] ADDR_ENA_PRI = {IDX_ENA_PRI, 2'b00};
   localparam logic [11:0] ADDR_PRIO_PRI = {IDX_PRIO_PRI, 2'b00};
   localparam logic [11:0] ADDR_ENA_EXT = {IDX_ENA_EXT, 2'b00};
   localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
   // reset values
   localparam logic [7:0] ENA_PRI_RST = 8'h00;
   localparam logic [7:0] PRIO_PRI_RST = 8'h80;
   localparam logic [7:0] ENA_EXT_RST = 8'h00;
   // field positions
   localparam int GATE_BIT = 7;
   localparam int PRIO_RO_BIT = 7;
   localparam int PRIMARY_SRCS = 7;
   localparam int ST_HIGH = 4;
   localparam int ST_VALID = 5;
   localparam int ST_LOW_BUSY = 6;
   localparam int ST_HIGH_BUSY = 7;
   // source order numbers
   localparam logic [3:0] SRC_EXT0 = 4'h0;
   localparam logic [3:0] SRC_T2 = 4'h5;
   localparam logic [3:0] SRC_SPI = 4'h6;
   localparam logic [3:0] SRC_T3 = 4'he;
endpackage : iepb_pkg

/* File: iepb_core_model.sv */
`timescale 1ns/100ps
module iepb_core_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic irq_valid,
   input wire logic ack_en,
   input wire logic [7:0] svc_len,
   output logic irq_ack,
   output logic irq_return
);
   logic ack_q;
   logic [1:0] depth;
   logic [7:0] tmr;
   //////////////////////////////////////////////////
   // vector once per shown request; guard stops a second ack before busy lands
   assign irq_ack = irq_valid && ack_en && !ack_q;
   // return ends the innermost routine; never in the cycle of an ack
   assign irq_return = (depth != 2'd0) && (tmr == 8'h00) && !irq_ack;
   // ack history
   always_ff @(posedge sys_clk) begin
      if (rst) ack_q <= 1'b0;
      else ack_q <= irq_ack;
   end
   // nesting depth and service time; each entry or return restarts the timer
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         depth <= 2'd0;
         tmr <= 8'h00;
      end else if (irq_ack) begin
         depth <= depth + 2'd1;
         tmr <= svc_len;
      end else if (irq_return) begin
         depth <= depth - 2'd1;
         tmr <= svc_len;
      end else if (tmr != 8'h00) begin
         tmr <= tmr - 8'h01;
      end
   end
endmodule : iepb_core_model

/* File: tb_interrupt_enable_priority_bank.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_interrupt_enable_priority_bank;
   import iepb_pkg::*;
   logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, ack_en;
   logic irq_ack, irq_return, irq_valid, irq_high;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [SRCW-1:0] irq_source;
   logic [19:0] fl;
   logic [7:0] svc;
   int fail_count = 0;
   int n_tests = 0;
   // flag index per source; paired sources use their second flag
   localparam int FI[15] = '{0, 1, 2, 3, 4, 6, 7, 8, 10, 11, 12, 13, 15, 17, 19};
   // first flag of each pair and the order number of its source
   localparam int FA[5] = '{5, 9, 14, 16, 18};
   localparam int SA[5] = '{5, 8, 12, 13, 14};
   //////////////////////////////////////////////////
   iepb_top DUT (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_line_zero_n(~fl[0]), .ext_line_one_n(~fl[2]),
      .timer_zero_overflow(fl[1]), .timer_one_overflow(fl[3]),
      .async_serial_unit_flag(fl[4]), .timer_two_low_overflow(fl[5]),
      .timer_two_high_overflow(fl[6]), .serial_periph_flag(fl[7]),
      .two_wire_bus_unit_flag(fl[8]), .rt_clock_alarm_flag(fl[9]),
      .rt_clock_osc_lost_flag(fl[10]), .conv_window_flag(fl[11]), .conv_done_flag(fl[12]),
      .counter_array_unit_flag(fl[13]), .comparator_zero_rise_flag(fl[14]),
      .comparator_zero_fall_flag(fl[15]), .comparator_one_rise_flag(fl[16]),
      .comparator_one_fall_flag(fl[17]), .timer_three_low_overflow(fl[18]),
      .timer_three_high_overflow(fl[19]), .irq_ack(irq_ack), .irq_return(irq_return),
      .irq_valid(irq_valid), .irq_source(irq_source), .irq_high(irq_high));
   iepb_core_model core (.sys_clk(sys_clk), .rst(rst), .irq_valid(irq_valid),
      .ack_en(ack_en), .svc_len(svc), .irq_ack(irq_ack), .irq_return(irq_return));
   //////////////////////////////////////////////////
   // free-running clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : wt
   // apb master; request held until pready seen high at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1 && k < 20) begin
         @(posedge sys_clk);
         k++;
      end
      if (k == 20) fail_count++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   // masked read compare, no error expected
   task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      `CHK(r & m, x)
      `CHK(e, 1'b0)
   endtask : rdc
   //////////////////////////////////////////////////
   // reset values, access kinds, upper bits, unmapped place
   task automatic t_regs;
      logic [31:0] r;
      logic e;
      rdc(ADDR_ENA_PRI, 32'hffffffff, 32'h00);
      rdc(ADDR_PRIO_PRI, 32'hffffffff, 32'h80);
      rdc(ADDR_ENA_EXT, 32'hffffffff, 32'h00);
      wr(ADDR_ENA_PRI, 32'hffffff5a);
      wr(ADDR_PRIO_PRI, 32'h0000005a);
      wr(ADDR_ENA_EXT, 32'h000000a5);
      wr(12'h000, 32'h000000ff);
      apb(1'b0, 12'h000, 32'h0, r, e);
      `CHK({e, r}, 33'h100000000)
      rdc(ADDR_ENA_PRI, 32'hffffffff, 32'h5a);
      rdc(ADDR_PRIO_PRI, 32'hffffffff, 32'hda);
      rdc(ADDR_ENA_EXT, 32'hffffffff, 32'ha5);
      wr(ADDR_PRIO_PRI, 32'h0);
      rdc(ADDR_PRIO_PRI, 32'hffffffff, 32'h80);
   endtask : t_regs
   // each source: own mask off, then on, then gate off
   task automatic t_gate;
      logic [7:0] m;
      for (int i = 0; i < 15; i++) begin
         fl <= 20'h1 << FI[i];
         m = 8'h01 << ((i < 7) ? i : i - 7);
         wr(ADDR_ENA_PRI, {24'h0, (i < 7) ? ~m : 8'hff});
         wr(ADDR_ENA_EXT, {24'h0, (i < 7) ? 8'hff : ~m});
         wt(6);
         `CHK(irq_valid, 1'b0)
         wr(ADDR_ENA_PRI, 32'hff);
         wr(ADDR_ENA_EXT, 32'hff);
         wt(6);
         `CHK({irq_valid, irq_high, irq_source}, {2'b10, SRCW'(i)})
         wr(ADDR_ENA_PRI, 32'h7f);
         wt(3);
         `CHK(irq_valid, 1'b0)
      end
      fl <= 20'h0;
   endtask : t_gate
   // priority bit per source, then fixed order among equals
   task automatic t_arb;
      wr(ADDR_ENA_PRI, 32'hff);
      fl <= 20'h400ff;
      for (int k = 0; k < 7; k++) begin
         wr(ADDR_PRIO_PRI, 32'h1 << k);
         wt(6);
         `CHK({irq_high, irq_source}, {1'b1, SRCW'(k)})
      end
      wr(ADDR_PRIO_PRI, 32'h0);
      wt(6);
      `CHK({irq_high, irq_source}, {1'b0, SRC_EXT0})
      fl <= 20'h40100;
      wt(6);
      `CHK({irq_valid, irq_source}, {1'b1, SRCW'(7)})
      // the other flag of each pair raises the same source on its own
      for (int k = 0; k < 5; k++) begin
         fl <= 20'h1 << FA[k];
         wt(3);
         `CHK({irq_valid, irq_source}, {1'b1, SRCW'(SA[k])})
      end
      fl <= 20'h0;
      wr(ADDR_ENA_EXT, 32'h0);
   endtask : t_arb
   // low in service, high preempts, nothing preempts high
   task automatic t_pre;
      wr(ADDR_PRIO_PRI, 32'h03);
      wr(ADDR_ENA_PRI, 32'hc3);
      svc <= 8'd100;
      ack_en <= 1'b1;
      fl <= 20'h80;
      wt(8);
      rdc(ADDR_STATUS, 32'hc0, 32'h40);
      `CHK(irq_valid, 1'b0)
      fl <= 20'h82;
      wt(8);
      rdc(ADDR_STATUS, 32'hc0, 32'hc0);
      fl <= 20'h83;
      wt(8);
      `CHK(irq_valid, 1'b0)
      ack_en <= 1'b0;
      fl <= 20'h0;
      wt(250);
      rdc(ADDR_STATUS, 32'hc0, 32'h00);
   endtask : t_pre
   //////////////////////////////////////////////////
   task automatic end_sim;
      $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   // watchdog, well beyond the roughly nine hundred cycles the tests take
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      end_sim();
   end
   // main sequence
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      fl = 20'h0;
      ack_en = 1'b0;
      svc = 8'd10;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_regs();
      t_gate();
      t_arb();
      t_pre();
      end_sim();
   end
endmodule : tb_interrupt_enable_priority_bank
